// ===== src/adcc_pkg.sv
package adcc_pkg;

    localparam logic [7:0] OFS_SC1      = 8'h00;
    localparam logic [7:0] OFS_SC2      = 8'h04;
    localparam logic [7:0] OFS_RES_HI   = 8'h08;
    localparam logic [7:0] OFS_RES_LO   = 8'h0C;
    localparam logic [7:0] OFS_CMP_HI   = 8'h10;
    localparam logic [7:0] OFS_CMP_LO   = 8'h14;
    localparam logic [7:0] OFS_CFG      = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
    localparam int SC2_ACT_BIT  = 7;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LOST_BIT = 1;

    localparam logic [4:0] CH_DISABLED = 5'h1F;
    localparam logic [4:0] CH_HIGH_REF = 5'h1D;
    localparam logic [4:0] CH_LOW_REF  = 5'h1E;

    localparam logic [1:0] MODE_8  = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;

    localparam logic [6:0]  SC1_RST  = 7'h1F;
    localparam logic [2:0]  SC2_RST  = 3'h0;
    localparam logic [11:0] CMP_RST  = 12'h000;
    localparam logic [1:0]  CFG_RST  = 2'h0;
    localparam logic [1:0]  IRQ_RST  = 2'h0;

    typedef struct packed {
        logic       complete_irq_enable;
        logic       cont;
        logic [4:0] ch;
    } adcc_sc1_t;

    typedef struct packed {
        logic trg;
        logic compare_enable;
        logic compare_ge_select;
    } adcc_sc2_t;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       power_down;
        logic [4:0] channel;
    } adcc_core_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } adcc_state_t;

endpackage

// ===== src/adcc_ctrl.sv
`timescale 1ns/10ps
module adcc_ctrl
    import adcc_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           ce,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           hw_trigger_in,
    input  wire logic           core_done,
    input  wire logic [11:0]    core_result,
    output adcc_core_req_t      core_req,
    output logic                irq
);

    function automatic logic adcc_mapped(input logic [7:0] a);
        case (a)
            OFS_SC1, OFS_SC2, OFS_RES_HI, OFS_RES_LO,
            OFS_CMP_HI, OFS_CMP_LO, OFS_CFG,
            OFS_IRQ_STAT, OFS_IRQ_MASK: adcc_mapped = 1'b1;
            default: adcc_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [11:0] adcc_mask(input logic [1:0] m);
        case (m)
            MODE_12: adcc_mask = 12'hFFF;
            MODE_10: adcc_mask = 12'h3FF;
            default: adcc_mask = 12'h0FF;
        endcase
    endfunction

    adcc_sc1_t      sc1_q;
    adcc_sc2_t      sc2_q;
    adcc_state_t    state_q;
    adcc_state_t    state_d;
    adcc_core_req_t req_q;
    logic [11:0]    cmp_q;
    logic [11:0]    result_q;
    logic [1:0]     mode_q;
    logic [1:0]     irq_stat_q;
    logic [1:0]     irq_mask_q;
    logic           conversion_complete_flag_q;
    logic           lock_q;
    logic           irq_q;
    logic [31:0]    prdata_q;
    logic           slverr_q;
    logic           trg_meta_q;
    logic           trg_sync_q;
    logic           trg_prev_q;

    logic           acc;
    logic           wr_acc;
    logic           rd_acc;
    logic           sc1_wr;
    logic           rh_rd;
    logic           rl_rd;
    logic           hw_edge;
    logic           sw_start;
    logic           hw_start;
    logic           busy;
    logic           done_ok;
    logic           cont_next;
    logic [11:0]    wmask;
    logic [11:0]    res_m;
    logic [11:0]    cmp_m;
    logic [11:0]    diff;
    logic           cmp_true;
    logic           hit;
    logic           store;
    logic           lost;

    // apb: read data captured in setup, access phase ends at once
    assign acc    = psel & penable & ce;
    assign pready = acc;
    assign wr_acc = acc & pwrite & adcc_mapped(paddr);
    assign rd_acc = acc & ~pwrite & adcc_mapped(paddr);
    assign sc1_wr = wr_acc & (paddr == OFS_SC1);
    assign rh_rd  = rd_acc & (paddr == OFS_RES_HI);
    assign rl_rd  = rd_acc & (paddr == OFS_RES_LO);
    assign prdata  = prdata_q;
    assign pslverr = acc & slverr_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (ce && psel && !penable) begin
            slverr_q <= ~adcc_mapped(paddr);
            case (paddr)
                OFS_SC1:      prdata_q <= {24'h0, conversion_complete_flag_q, sc1_q};
                OFS_SC2:      prdata_q <= {24'h0, busy, sc2_q, 4'h0};
                OFS_RES_HI:   prdata_q <= {28'h0, result_q[11:8]};
                OFS_RES_LO:   prdata_q <= {24'h0, result_q[7:0]};
                OFS_CMP_HI:   prdata_q <= {28'h0, cmp_q[11:8]};
                OFS_CMP_LO:   prdata_q <= {24'h0, cmp_q[7:0]};
                OFS_CFG:      prdata_q <= {30'h0, mode_q};
                OFS_IRQ_STAT: prdata_q <= {30'h0, irq_stat_q};
                OFS_IRQ_MASK: prdata_q <= {30'h0, irq_mask_q};
                default:      prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc1_q      <= SC1_RST;
            sc2_q      <= SC2_RST;
            cmp_q      <= CMP_RST;
            mode_q     <= CFG_RST;
            irq_mask_q <= IRQ_RST;
        end else if (ce && wr_acc) begin
            case (paddr)
                OFS_SC1:      sc1_q <= pwdata[6:0];
                OFS_SC2:      sc2_q <= pwdata[6:4];
                OFS_CMP_HI:   cmp_q[11:8] <= pwdata[3:0];
                OFS_CMP_LO:   cmp_q[7:0] <= pwdata[7:0];
                OFS_CFG:      mode_q <= pwdata[1:0];
                OFS_IRQ_MASK: irq_mask_q <= pwdata[1:0];
                default:      ;
            endcase
        end
    end

    // overflow pulse comes from the counter's own clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trg_meta_q <= 1'b0;
            trg_sync_q <= 1'b0;
            trg_prev_q <= 1'b0;
        end else if (ce) begin
            trg_meta_q <= hw_trigger_in;
            trg_sync_q <= trg_meta_q;
            trg_prev_q <= trg_sync_q;
        end
    end

    assign hw_edge = trg_sync_q & ~trg_prev_q;
    assign busy    = (state_q == ST_CONV);

    // a write with all-ones channel aborts and stays off
    assign sw_start = sc1_wr & (pwdata[4:0] != CH_DISABLED)
                    & ~sc2_q.trg;
    // triggers while busy are dropped, not queued
    assign hw_start = hw_edge & sc2_q.trg & ~busy & ~sc1_wr
                    & (sc1_q.ch != CH_DISABLED);
    // abort from a write wins over a coincident completion
    assign done_ok   = core_done & busy & ~sc1_wr;
    assign cont_next = done_ok & sc1_q.cont
                     & (sc1_q.ch != CH_DISABLED);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (sw_start || hw_start) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sc1_wr) begin
                    state_d = sw_start ? ST_CONV : ST_IDLE;
                end else if (done_ok) begin
                    state_d = cont_next ? ST_CONV : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // core request: start and abort are one-cycle pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '{1'b0, 1'b0, 1'b1, CH_DISABLED};
        end else if (ce) begin
            req_q.start      <= sw_start | hw_start | cont_next;
            req_q.abort      <= sc1_wr & busy;
            req_q.power_down <= (state_d == ST_IDLE);
            req_q.channel    <= sc1_wr ? pwdata[4:0] : sc1_q.ch;
        end
    end
    assign core_req = req_q;

    // compare and result path, width set by conversion mode
    assign wmask = adcc_mask(mode_q);
    assign res_m = core_result & wmask;
    assign cmp_m = cmp_q & wmask;
    assign diff  = (res_m + (~cmp_m + 12'h001)) & wmask;
    assign cmp_true = sc2_q.compare_ge_select ? (res_m >= cmp_m)
                                  : (res_m < cmp_m);
    assign hit   = done_ok & (~sc2_q.compare_enable | cmp_true);
    assign store = hit & ~lock_q;
    assign lost  = hit & lock_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= 12'h000;
        end else if (ce && store) begin
            result_q <= sc2_q.compare_enable ? diff : res_m;
        end
    end

    // interlock in every mode but MODE_8, so also in 8 bit mode 3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else if (ce) begin
            if (rl_rd || mode_q == MODE_8) begin
                lock_q <= 1'b0;
            end else if (rh_rd) begin
                lock_q <= 1'b1;
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_complete_flag_q <= 1'b0;
        end else if (ce) begin
            if (hit) begin
                conversion_complete_flag_q <= 1'b1;
            end else if (sc1_wr || rl_rd) begin
                conversion_complete_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= IRQ_RST;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (wr_acc && paddr == OFS_IRQ_STAT && pwdata[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
            if (hit && sc1_q.complete_irq_enable) begin
                irq_stat_q[IRQ_DONE_BIT] <= 1'b1;
            end
            if (lost) begin
                irq_stat_q[IRQ_LOST_BIT] <= 1'b1;
            end
        end
    end

    // completion source also gated by enable, never leaks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= (irq_stat_q[IRQ_DONE_BIT] & irq_mask_q[IRQ_DONE_BIT]
                      & sc1_q.complete_irq_enable)
                   | (irq_stat_q[IRQ_LOST_BIT]
                      & irq_mask_q[IRQ_LOST_BIT]);
        end
    end
    assign irq = irq_q;

    chk_sw_restart: assert property (@(posedge clk) disable iff (!rst_n)
        sw_start |=> busy && req_q.start)
        else $error("software write did not start conversion");

    chk_disable_stop: assert property (@(posedge clk) disable iff (!rst_n)
        sc1_wr && pwdata[4:0] == CH_DISABLED |=> !busy && !req_q.start)
        else $error("disabled channel still converted");

    chk_conversion_complete_flag_nocmp: assert property (@(posedge clk) disable iff (!rst_n)
        done_ok && !sc2_q.compare_enable |=> conversion_complete_flag_q)
        else $error("complete flag not set");

    chk_conversion_complete_flag_miss: assert property (@(posedge clk) disable iff (!rst_n)
        ce && done_ok && sc2_q.compare_enable && !cmp_true && !conversion_complete_flag_q && !rl_rd
        |=> !conversion_complete_flag_q)
        else $error("flag set without compare hit");

    chk_conversion_complete_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ce && (sc1_wr || rl_rd) && !hit |=> !conversion_complete_flag_q)
        else $error("complete flag not cleared");

    chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        irq && !$past(irq_stat_q[IRQ_LOST_BIT])
        |-> $past(sc1_q.complete_irq_enable))
        else $error("interrupt without enable");

    chk_single_idle: assert property (@(posedge clk) disable iff (!rst_n)
        ce && done_ok && !sc1_q.cont
        |=> !busy ##1 req_q.power_down)
        else $error("single conversion did not stop");

    chk_cont_rerun: assert property (@(posedge clk) disable iff (!rst_n)
        cont_next |=> busy && req_q.start)
        else $error("continuous conversion not restarted");

    chk_hw_start: assert property (@(posedge clk) disable iff (!rst_n)
        hw_start |=> busy && req_q.start)
        else $error("hardware trigger ignored");

    chk_active_flag: assert property (@(posedge clk) disable iff (!rst_n)
        req_q.abort |-> $past(busy))
        else $error("abort while not active");

    chk_cmp_store: assert property (@(posedge clk) disable iff (!rst_n)
        ce && store && sc2_q.compare_enable
        |=> result_q == $past(diff))
        else $error("compare result not stored");

    chk_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
        lock_q && done_ok |=> $stable(result_q))
        else $error("locked result overwritten");

    chk_ge_cmp: assert property (@(posedge clk) disable iff (!rst_n)
        done_ok && sc2_q.compare_enable && sc2_q.compare_ge_select && res_m >= cmp_m
        |-> hit)
        else $error("ge compare missed");

endmodule // adcc_ctrl

// ===== dv/adcc_core_model.sv
`timescale 1ns/10ps
module adcc_core_model
    import adcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  adcc_core_req_t   core_req,
    input  wire logic [3:0]  lat,
    input  wire logic [11:0] res_in,
    output logic             core_done,
    output logic [11:0]      core_result
);
    logic [3:0]  cnt_q;
    logic [11:0] junk_q;
    // restart reloads the latency, abort drops the pending strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 4'h0;
        else if (core_req.start) cnt_q <= lat;
        else if (core_req.abort) cnt_q <= 4'h0;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
    // bus churns outside the strobe, so no stale value can pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) junk_q <= 12'hA5C;
        else junk_q <= ~junk_q ^ 12'h5A3;
    end
    assign core_done   = (cnt_q == 4'h1) && !core_req.abort;
    assign core_result = core_done ? res_in : junk_q;
endmodule // adcc_core_model

// ===== dv/adc_conversion_control_test.sv
`timescale 1ns/10ps
module adc_conversion_control_test
    import adcc_pkg::*;
;
    logic           clk, rst_n, ce, psel, penable, pwrite, pready;
    logic           pslverr, hw_trigger_in, core_done, irq, err, h;
    logic [7:0]     paddr, r, c, last_res;
    logic [31:0]    pwdata, prdata, rdv, lfsr_q;
    logic [11:0]    core_result, res_in;
    logic [3:0]     lat;
    logic [4:0]     chs [6];
    adcc_core_req_t core_req;
    int             failures, checks, done_n, abort_n, n0, d0;

    adcc_ctrl i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_trigger_in(hw_trigger_in),
        .core_done(core_done), .core_result(core_result),
        .core_req(core_req), .irq(irq));
    adcc_core_model i_core (
        .clk(clk), .rst_n(rst_n), .core_req(core_req), .lat(lat),
        .res_in(res_in), .core_done(core_done),
        .core_result(core_result));

    always @(posedge clk) begin
        if (core_done === 1'b1) done_n++;
        if (core_req.abort === 1'b1) abort_n++;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic hit(input logic [7:0] a, b, input logic ge);
        return ge ? (a >= b) : (a < b);
    endfunction

    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, e);
        checks++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask
    // one idle cycle between transfers keeps each strobe edge clean
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            tally_and_finish();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rdv, e);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (core_done !== 1'b1 && n < 60);
        if (n >= 60) begin
            failures++;
            tally_and_finish();
        end
        repeat (2) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        hw_trigger_in = 1'b0; lat = 4'h8; res_in = 12'h000;
        lfsr_q = 32'h110C868B; failures = 0; checks = 0;
        done_n = 0; abort_n = 0;
        chs = '{5'h00, 5'h0F, 5'h10, 5'h1B, CH_HIGH_REF, CH_LOW_REF};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc("sc1rst", OFS_SC1, 32'h1F);
        rdc("sc2rst", OFS_SC2, 32'h0);
        chk("pdrst", 32'(core_req.power_down), 32'h1);
        rdc("unmapped", 8'h40, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        wr(OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            res_in <= {4'h0, lfsr_q[7:0]};
            lat <= 4'h8 | lfsr_q[10:8];
            wr(OFS_SC1, {25'h0, i[0], 1'b0, chs[i]});
            rdc("actrun", OFS_SC2, 32'h80);
            // channel level is settled well after the write edge
            chk("chan", 32'(core_req.channel), 32'(chs[i]));
            wait_done();
            chk("irq", 32'(irq), 32'(i[0]));
            chk("pdown", 32'(core_req.power_down), 32'h1);
            rdc("actend", OFS_SC2, 32'h0);
            rdc("conversion_complete_flag", OFS_SC1,
                {24'h0, 1'b1, i[0], 1'b0, chs[i]});
            rdc("res", OFS_RES_LO, 32'(res_in[7:0]));
            rdc("cococlr", OFS_SC1,
                {25'h0, i[0], 1'b0, chs[i]});
            wr(OFS_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk);
            chk("irqclr", 32'(irq), 32'h0);
        end
        last_res = res_in[7:0];
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            r = lfsr_q[7:0];
            c = (i == 0 || i == 2) ? r : lfsr_q[15:8];
            wr(OFS_SC2, {26'h0, 1'b1, i[1], 4'h0});
            wr(OFS_CMP_LO, 32'(c));
            res_in <= {4'h0, r};
            wr(OFS_SC1, 32'h05);
            wait_done();
            h = hit(r, c, i[1]);
            if (h) last_res = r - c;
            rdc("cmpflag", OFS_SC1, {24'h0, h, 7'h05});
            rdc("cmpres", OFS_RES_LO, 32'(last_res));
        end
        wr(OFS_SC2, 32'h40);
        res_in <= 12'h0A5;
        wr(OFS_SC1, 32'h02);
        repeat (20) @(posedge clk);
        rdc("hwidle", OFS_SC2, 32'h40);
        n0 = done_n;
        hw_trigger_in <= 1'b1;
        repeat (3) @(posedge clk);
        hw_trigger_in <= 1'b0;
        wait_done();
        chk("hwruns", 32'(done_n - n0), 32'h1);
        rdc("hwres", OFS_RES_LO, 32'h0A5);
        wr(OFS_SC2, 32'h0);
        lat <= 4'h4;
        n0 = done_n;
        wr(OFS_SC1, 32'h21);
        repeat (60) @(posedge clk);
        chk("contruns", 32'(done_n - n0 >= 8), 32'h1);
        wr(OFS_SC1, 32'h3F);
        @(posedge clk);
        n0 = done_n;
        repeat (30) @(posedge clk);
        chk("stopruns", 32'(done_n - n0), 32'h0);
        rdc("stopact", OFS_SC2, 32'h0);
        lat <= 4'hF;
        wr(OFS_SC1, 32'h03);
        n0 = abort_n;
        d0 = done_n;
        wr(OFS_SC1, 32'h04);
        wait_done();
        repeat (20) @(posedge clk);
        chk("abort", 32'(abort_n - n0), 32'h1);
        chk("single", 32'(done_n - d0), 32'h1);
        rdc("abres", OFS_SC1, 32'h84);
        // 12 bit mode: high read locks, next result is lost
        wr(OFS_CFG, 32'h1);
        res_in <= 12'h123;
        wr(OFS_SC1, 32'h06);
        wait_done();
        rdc("hi12", OFS_RES_HI, 32'h1);
        res_in <= 12'h456;
        wr(OFS_SC1, 32'h06);
        wait_done();
        rdc("lockhi", OFS_RES_HI, 32'h1);
        rdc("locklo", OFS_RES_LO, 32'h23);
        rdc("lost", OFS_IRQ_STAT, 32'h2);
        tally_and_finish();
    end
endmodule // adc_conversion_control_test
